// File: lidec_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the unique-id and error-capture registers.
// Assumes: APB byte addresses with one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef LIDEC_DEFINES_SVH
`define LIDEC_DEFINES_SVH

`define LIDEC_ADDR_W 8
`define LIDEC_OFS_UID_LO 8'h28
`define LIDEC_OFS_ROM_BASE 8'h34
`define LIDEC_OFS_FW_LO 8'h38
`define LIDEC_OFS_FW_HI 8'h3c
`define LIDEC_OFS_COMPANY 8'h40
`define LIDEC_OFS_STATUS 8'h44
`define LIDEC_OFS_MASK 8'h48
`define LIDEC_WORD_ALIGN 2'h0

`define LIDEC_UID_RESET 32'h0000_0000
`define LIDEC_BASE_RESET 22'h00_0000
`define LIDEC_RSVD_ZERO 10'h000
`define LIDEC_WIN_LSBS 10
// The value is arbitrary and identifies no organisation.
`define LIDEC_COMPANY_CODE 32'h00a5_5a01

`define LIDEC_ROM_WIN_LO 48'hffff_f000_0400
`define LIDEC_ROM_WIN_HI 48'hffff_f000_07ff

`define LIDEC_EV_N 3
`define LIDEC_EV_FAIL 0
`define LIDEC_EV_ROM 1
`define LIDEC_EV_UID 2

`endif

// File: lidec_pkg.sv
// Purpose: State types of the unique-id and error-capture register bank.
// Assumes: lidec_defines.svh is compiled alongside.
// Notes: lidec_regs and lidec_capture keep their design registers in these structs; the assertion helpers sit outside.
`include "lidec_defines.svh"

package lidec_pkg;

  typedef struct packed {
    logic [31:0] uid_lo;
    logic uid_locked;
    logic [21:0] rom_base;
    logic [`LIDEC_EV_N-1:0] status;
    logic [`LIDEC_EV_N-1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [31:0] host_addr;
    logic host_addr_valid;
  } lidec_regs_s;

  typedef struct packed {
    logic [31:0] low;
    logic [31:0] high;
  } lidec_cap_s;

endpackage

// File: lidec_cap_if.sv
// Purpose: Carries a failed posted write into the capture registers and their contents back.
// Assumes: All signals are on sys_clk.
// Notes: fail is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

interface lidec_cap_if;
  logic fail;
  logic [47:0] offset;
  logic [9:0] bus_num;
  logic [5:0] node_num;
  logic [31:0] low;
  logic [31:0] high;
  modport capt (input fail, input offset, input bus_num, input node_num,
                output low, output high);
  modport regs (output fail, output offset, output bus_num, output node_num,
                input low, input high);
endinterface

`default_nettype wire

// File: lidec_capture.sv
// Purpose: Holds the offset and requester of the most recent failed posted write.
// Assumes: fail is a single-cycle pulse on sys_clk.
// Notes: The contents have no reset value; sys_rst only gates the assertions.
`timescale 1ns/1ps
`default_nettype none

module lidec_capture (
  input wire logic sys_clk,
  input wire logic sys_rst,
  lidec_cap_if.capt cap
);

  lidec_pkg::lidec_cap_s cap_reg;
  lidec_pkg::lidec_cap_s cap_next;

  always_comb begin
    cap_next = cap_reg;
    if (cap.fail) begin
      cap_next.low = cap.offset[31:0];
      cap_next.high = {cap.bus_num, cap.node_num, cap.offset[47:32]};
    end
  end

  // No reset: software must not trust these until a failure has been seen.
  always_ff @(posedge sys_clk) begin
    cap_reg <= cap_next;
  end

  assign cap.low = cap_reg.low;
  assign cap.high = cap_reg.high;

  logic seen_reg;
  logic [31:0] exp_low;
  logic [15:0] exp_src;
  logic [15:0] exp_hi;
  assign exp_low = cap.offset[31:0];
  assign exp_src = {cap.bus_num, cap.node_num};
  assign exp_hi = cap.offset[47:32];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seen_reg <= 1'b0;
    end else if (cap.fail) begin
      seen_reg <= 1'b1;
    end
  end

  a_low_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cap.fail |=> cap.low == $past(exp_low)) else $error("failed offset low not captured");
  a_source_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cap.fail |=> cap.high[31:16] == $past(exp_src)) else $error("requester not captured");
  a_high_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cap.fail |=> cap.high[15:0] == $past(exp_hi)) else $error("failed offset high wrong");
  a_capture_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seen_reg && !cap.fail |=> $stable(cap.low) && $stable(cap.high))
    else $error("capture changed without a failure");
  c_two_failures: cover property (@(posedge sys_clk) disable iff (sys_rst)
    cap.fail ##1 cap.fail);

endmodule

`default_nettype wire

// File: lidec_regs.sv
// Purpose: Lower unique id, configuration ROM window base, failed-write capture and company id.
// Assumes: APB slave on sys_clk; serial-bus and EEPROM strobes come from logic on sys_clk.
// Notes: Zero-wait APB; pslverr on unmapped or unaligned addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lidec_defines.svh"

// Summary of operation
// - Lower id register at 0x28, reset zero.
// - Lower id is low quadlet of identifier.
// - EEPROM loads lower id once, then locked.
// - ROM window reads add low bits to base.
// - Base bits 31..10 writable, 9..0 read zero.
// - Failed write stores low offset word.
// - Failed write stores bus and node number.
// - Failed write stores high offset bits.
// - Capture registers read only, no reset value.
// - Fixed company code readable at 0x40.
module lidec_regs #(
  parameter logic [31:0] COMPANY_CODE = `LIDEC_COMPANY_CODE
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`LIDEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_detected,
  input wire logic eeprom_uid_valid,
  input wire logic [31:0] eeprom_uid_lower,
  input wire logic rom_rd_req,
  input wire logic [47:0] rom_rd_offset,
  output logic [31:0] rom_host_addr,
  output logic rom_host_addr_valid,
  input wire logic pw_fail,
  input wire logic [47:0] pw_fail_offset,
  input wire logic [9:0] pw_fail_bus,
  input wire logic [5:0] pw_fail_node,
  output logic [31:0] unique_id_lower_part,
  output logic irq
);

  lidec_pkg::lidec_regs_s st_reg;
  lidec_pkg::lidec_regs_s st_next;

  lidec_cap_if cap ();

  assign cap.fail = pw_fail;
  assign cap.offset = pw_fail_offset;
  assign cap.bus_num = pw_fail_bus;
  assign cap.node_num = pw_fail_node;

  lidec_capture u_capture (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cap(cap.capt)
  );

  logic setup;
  logic done;
  logic aligned;
  logic hit;
  logic [31:0] rd_word;
  logic rom_hit;
  logic uid_load;
  logic [`LIDEC_EV_N-1:0] ev;

  assign setup = psel & ~penable;
  assign done = psel & penable & st_reg.pready;
  assign aligned = paddr[1:0] == `LIDEC_WORD_ALIGN;
  assign rom_hit = rom_rd_req && rom_rd_offset >= `LIDEC_ROM_WIN_LO &&
                   rom_rd_offset <= `LIDEC_ROM_WIN_HI;
  assign uid_load = eeprom_detected && eeprom_uid_valid && !st_reg.uid_locked;

  always_comb begin
    ev = '0;
    ev[`LIDEC_EV_FAIL] = pw_fail;
    ev[`LIDEC_EV_ROM] = rom_hit;
    ev[`LIDEC_EV_UID] = uid_load;
  end

  // Read decode; no read has a side effect except the status clear at completion.
  always_comb begin
    rd_word = '0;
    hit = aligned;
    case (paddr)
      `LIDEC_OFS_UID_LO: rd_word = st_reg.uid_lo;
      `LIDEC_OFS_ROM_BASE: rd_word = {st_reg.rom_base, `LIDEC_RSVD_ZERO};
      `LIDEC_OFS_FW_LO: rd_word = cap.low;
      `LIDEC_OFS_FW_HI: rd_word = cap.high;
      `LIDEC_OFS_COMPANY: rd_word = COMPANY_CODE;
      `LIDEC_OFS_STATUS: rd_word[`LIDEC_EV_N-1:0] = st_reg.status;
      `LIDEC_OFS_MASK: rd_word[`LIDEC_EV_N-1:0] = st_reg.mask;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.pready = setup;
    st_next.pslverr = setup & ~hit;
    if (setup) begin
      st_next.prdata = rd_word;
    end
    if (done && pwrite) begin
      if (paddr == `LIDEC_OFS_ROM_BASE) begin
        st_next.rom_base = pwdata[31:`LIDEC_WIN_LSBS];
      end
      if (paddr == `LIDEC_OFS_MASK) begin
        st_next.mask = pwdata[`LIDEC_EV_N-1:0];
      end
    end
    // Only the bits shown to software are cleared, so an event that lands
    // between the setup and the access cycle is still pending afterwards.
    if (done && !pwrite && paddr == `LIDEC_OFS_STATUS) begin
      st_next.status = st_reg.status & ~st_reg.prdata[`LIDEC_EV_N-1:0];
    end
    st_next.status = st_next.status | ev;
    if (uid_load) begin
      st_next.uid_lo = eeprom_uid_lower;
      st_next.uid_locked = 1'b1;
    end
    st_next.host_addr_valid = rom_hit;
    if (rom_hit) begin
      st_next.host_addr = {st_reg.rom_base, `LIDEC_RSVD_ZERO} +
                          {22'h00_0000, rom_rd_offset[`LIDEC_WIN_LSBS-1:0]};
    end
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.uid_lo <= `LIDEC_UID_RESET;
      st_reg.rom_base <= `LIDEC_BASE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign rom_host_addr = st_reg.host_addr;
  assign rom_host_addr_valid = st_reg.host_addr_valid;
  assign unique_id_lower_part = st_reg.uid_lo;
  assign irq = st_reg.irq;

  logic [31:0] exp_host;
  logic [21:0] wr_base;
  logic rd_done;
  assign exp_host = {st_reg.rom_base, `LIDEC_RSVD_ZERO} |
                    {22'h00_0000, rom_rd_offset[`LIDEC_WIN_LSBS-1:0]};
  assign wr_base = pwdata[31:`LIDEC_WIN_LSBS];
  assign rd_done = done && !pwrite;

  a_uid_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> unique_id_lower_part == `LIDEC_UID_RESET)
    else $error("lower id not zero after reset");
  a_uid_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && paddr == `LIDEC_OFS_UID_LO |-> prdata == $past(unique_id_lower_part))
    else $error("lower id read differs from exported id");
  a_uid_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    uid_load |=> unique_id_lower_part == $past(eeprom_uid_lower))
    else $error("EEPROM id not loaded");
  a_uid_locked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_reg.uid_locked |=> $stable(unique_id_lower_part))
    else $error("lower id changed after load");
  a_rom_translate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rom_hit |=> rom_host_addr_valid && rom_host_addr == $past(exp_host))
    else $error("ROM window address wrong");
  a_rom_outside: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rom_rd_req && !rom_hit |=> !rom_host_addr_valid)
    else $error("read outside ROM window translated");
  a_base_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && paddr == `LIDEC_OFS_ROM_BASE |-> prdata[9:0] == 10'h000)
    else $error("reserved base bits not zero");
  a_base_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    done && pwrite && paddr == `LIDEC_OFS_ROM_BASE |=> st_reg.rom_base == $past(wr_base))
    else $error("base write lost");
  a_company_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && paddr == `LIDEC_OFS_COMPANY |-> prdata == COMPANY_CODE && !pslverr)
    else $error("company code wrong");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq == |(st_reg.status & st_reg.mask)) else $error("interrupt level wrong");
  a_fail_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pw_fail |=> st_reg.status[`LIDEC_EV_FAIL]) else $error("failure event lost");

  // Helper state for the checks below; none of it reaches an output.
  // The capture holds X until the first failure, so its read checks wait for one.
  logic cap_seen_reg;
  logic st_rd;
  logic wr_done;
  assign st_rd = rd_done && paddr == `LIDEC_OFS_STATUS;
  assign wr_done = done && pwrite;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cap_seen_reg <= 1'b0;
    end else if (pw_fail) begin
      cap_seen_reg <= 1'b1;
    end
  end

  // Bus timing: one access cycle, errors only with ready, read data held.
  a_ready_setup: assert property (@(posedge sys_clk) disable iff (sys_rst)
    setup |=> pready) else $error("ready missing after setup");
  a_ready_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !setup |=> !pready) else $error("ready without setup");
  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pready |=> !pready) else $error("ready longer than one cycle");
  a_done_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && penable |-> pready) else $error("wait state inserted");
  a_err_ready: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pslverr |-> pready) else $error("error without ready");
  a_err_unaligned: assert property (@(posedge sys_clk) disable iff (sys_rst)
    setup && paddr[1:0] != `LIDEC_WORD_ALIGN |=> pslverr) else $error("unaligned not refused");
  a_err_mapped: assert property (@(posedge sys_clk) disable iff (sys_rst)
    setup && paddr == `LIDEC_OFS_UID_LO |=> !pslverr) else $error("mapped register refused");
  a_err_data_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && pslverr |-> prdata == 32'h0000_0000) else $error("refused read data not zero");
  a_prdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !setup |=> $stable(prdata)) else $error("read data changed without setup");

  // Register contents and write paths.
  a_mask_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_done && paddr == `LIDEC_OFS_MASK |=> st_reg.mask == $past(pwdata[`LIDEC_EV_N-1:0]))
    else $error("mask write lost");
  a_mask_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(wr_done && paddr == `LIDEC_OFS_MASK) |=> $stable(st_reg.mask))
    else $error("mask changed without write");
  a_base_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && paddr == `LIDEC_OFS_ROM_BASE |-> prdata[31:`LIDEC_WIN_LSBS] == $past(st_reg.rom_base))
    else $error("base read differs");
  a_base_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(wr_done && paddr == `LIDEC_OFS_ROM_BASE) |=> $stable(st_reg.rom_base))
    else $error("base changed without write");
  a_uid_no_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_done && paddr == `LIDEC_OFS_UID_LO && !uid_load |=> $stable(unique_id_lower_part))
    else $error("software changed lower id");
  a_uid_unloaded: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st_reg.uid_locked |-> unique_id_lower_part == `LIDEC_UID_RESET)
    else $error("lower id not zero before load");
  a_uid_no_eeprom: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !eeprom_detected |=> $stable(unique_id_lower_part))
    else $error("lower id changed without EEPROM");
  a_uid_lock_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    uid_load |=> st_reg.uid_locked)
    else $error("lower id not locked after load");

  // Events: each sets its status bit; only a status read lets a bit fall.
  a_rom_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rom_hit |=> st_reg.status[`LIDEC_EV_ROM]) else $error("translate event lost");
  a_uid_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    uid_load |=> st_reg.status[`LIDEC_EV_UID]) else $error("load event lost");
  a_status_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !st_rd |=> ($past(st_reg.status) & ~st_reg.status) == '0)
    else $error("status bit fell without read");
  a_status_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_rd && ev == '0 |=> (st_reg.status & $past(st_reg.prdata[`LIDEC_EV_N-1:0])) == '0)
    else $error("status read did not clear");
  // A mask write in the same cycle may hide the interrupt, hence the guard.
  a_fail_irq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pw_fail && st_reg.mask[`LIDEC_EV_FAIL] && !wr_done |=> irq)
    else $error("unmasked failure gave no interrupt");

  // Translation output and capture read-back.
  a_rom_valid_src: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rom_rd_req |=> !rom_host_addr_valid) else $error("translation without request");
  a_rom_addr_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rom_hit |=> $stable(rom_host_addr)) else $error("host address changed without hit");
  a_fw_lo_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && $past(cap_seen_reg) && paddr == `LIDEC_OFS_FW_LO |-> prdata == $past(cap.low))
    else $error("failed offset low read differs");
  a_fw_hi_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && $past(cap_seen_reg) && paddr == `LIDEC_OFS_FW_HI |-> prdata == $past(cap.high))
    else $error("failed offset high read differs");

  c_rom_translate: cover property (@(posedge sys_clk) disable iff (sys_rst) rom_hit);
  c_fail_irq: cover property (@(posedge sys_clk) disable iff (sys_rst)
    pw_fail ##[1:4] irq);
  c_status_clear: cover property (@(posedge sys_clk) disable iff (sys_rst)
    rd_done && paddr == `LIDEC_OFS_STATUS && prdata != 32'h0000_0000);
  c_uid_load: cover property (@(posedge sys_clk) disable iff (sys_rst) uid_load);

endmodule

`default_nettype wire

// File: lidec_far_model.sv
// Purpose: Serial-bus requester and EEPROM loader facing the register bank.
// Assumes: Tasks are called just after a rising edge of sys_clk.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module lidec_far_model (
  input wire logic sys_clk,
  output logic rom_rd_req,
  output logic [47:0] rom_rd_offset,
  output logic pw_fail,
  output logic [47:0] pw_fail_offset,
  output logic [9:0] pw_fail_bus,
  output logic [5:0] pw_fail_node,
  output logic eeprom_uid_valid,
  output logic [31:0] eeprom_uid_lower
);
  initial begin
    rom_rd_req = 1'b0;
    rom_rd_offset = '0;
    pw_fail = 1'b0;
    pw_fail_offset = '0;
    pw_fail_bus = '0;
    pw_fail_node = '0;
    eeprom_uid_valid = 1'b0;
    eeprom_uid_lower = '0;
  end
  task automatic rom_read(input logic [47:0] ofs);
    rom_rd_req <= 1'b1;
    rom_rd_offset <= ofs;
    @(posedge sys_clk);
    rom_rd_req <= 1'b0;
    rom_rd_offset <= ~ofs;
  endtask
  task automatic fail(input logic [47:0] ofs, input logic [9:0] bus, input logic [5:0] node);
    pw_fail <= 1'b1;
    pw_fail_offset <= ofs;
    pw_fail_bus <= bus;
    pw_fail_node <= node;
    @(posedge sys_clk);
    pw_fail <= 1'b0;
    pw_fail_offset <= ~ofs;
    pw_fail_bus <= ~bus;
    pw_fail_node <= ~node;
  endtask
  task automatic uid_load(input logic [31:0] d);
    eeprom_uid_valid <= 1'b1;
    eeprom_uid_lower <= d;
    @(posedge sys_clk);
    eeprom_uid_valid <= 1'b0;
    eeprom_uid_lower <= ~d;
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: Register and event tests of the unique-id and error-capture bank.
// Assumes: Zero-wait APB slave; one idle cycle is left between transfers.
// Notes: Only mismatches and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none
`include "lidec_defines.svh"
module tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic eeprom_detected = 1'b0;
  logic [31:0] prdata, rom_host_addr, unique_id_lower_part, eeprom_uid_lower;
  logic pready, pslverr, rom_host_addr_valid, irq, eeprom_uid_valid, rom_rd_req, pw_fail;
  logic [47:0] rom_rd_offset, pw_fail_offset;
  logic [9:0] pw_fail_bus;
  logic [5:0] pw_fail_node;
  int n_fail = 0;
  int checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  lidec_regs i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eeprom_detected(eeprom_detected), .eeprom_uid_valid(eeprom_uid_valid),
    .eeprom_uid_lower(eeprom_uid_lower), .rom_rd_req(rom_rd_req), .rom_rd_offset(rom_rd_offset),
    .rom_host_addr(rom_host_addr), .rom_host_addr_valid(rom_host_addr_valid), .pw_fail(pw_fail),
    .pw_fail_offset(pw_fail_offset), .pw_fail_bus(pw_fail_bus), .pw_fail_node(pw_fail_node),
    .unique_id_lower_part(unique_id_lower_part), .irq(irq));
  lidec_far_model i_far (.sys_clk(sys_clk), .rom_rd_req(rom_rd_req),
    .rom_rd_offset(rom_rd_offset), .pw_fail(pw_fail), .pw_fail_offset(pw_fail_offset),
    .pw_fail_bus(pw_fail_bus), .pw_fail_node(pw_fail_node),
    .eeprom_uid_valid(eeprom_uid_valid), .eeprom_uid_lower(eeprom_uid_lower));
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // The idle edge keeps the next request from reassigning psel in this step.
    @(posedge sys_clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, exp, r);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic bad(input logic w, input logic [7:0] a);
    logic [31:0] r;
    logic e;
    apb(w, a, 32'hffff_ffff, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
    if (!w) chk("err_data", 32'h0, r);
  endtask
  task automatic rom(input logic [47:0] ofs, input logic hit, input logic [31:0] ea);
    i_far.rom_read(ofs);
    @(posedge sys_clk);
    chk("rom_valid", {31'h0, hit}, {31'h0, rom_host_addr_valid});
    if (hit) chk("rom_addr", ea, rom_host_addr);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd("uid_lo", `LIDEC_OFS_UID_LO, 32'h0);
    rd("rom_base", `LIDEC_OFS_ROM_BASE, 32'h0);
    rd("company", `LIDEC_OFS_COMPANY, `LIDEC_COMPANY_CODE);
    rd("mask", `LIDEC_OFS_MASK, 32'h0);
    wr(`LIDEC_OFS_UID_LO, 32'hffff_ffff);
    rd("uid_lo_ro", `LIDEC_OFS_UID_LO, 32'h0);
    wr(`LIDEC_OFS_COMPANY, 32'h0);
    rd("company_ro", `LIDEC_OFS_COMPANY, `LIDEC_COMPANY_CODE);
    bad(1'b0, 8'h4c);
    bad(1'b0, 8'h29);
    bad(1'b1, 8'h50);
    wr(`LIDEC_OFS_ROM_BASE, 32'hffff_ffff);
    rd("rom_base", `LIDEC_OFS_ROM_BASE, 32'hffff_fc00);
    wr(`LIDEC_OFS_ROM_BASE, 32'h1234_5bff);
    rom(48'hffff_f000_0400, 1'b1, 32'h1234_5800);
    rom(48'hffff_f000_07ff, 1'b1, 32'h1234_5bff);
    rom(48'hffff_f000_03ff, 1'b0, 32'h0);
    rom(48'hffff_f000_0800, 1'b0, 32'h0);
    wr(`LIDEC_OFS_MASK, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    i_far.fail(48'h1234_89ab_cdef, 10'h2a5, 6'h1b);
    @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    i_far.fail(48'h5678_0246_8ace, 10'h15a, 6'h24);
    repeat (20) @(posedge sys_clk);
    wr(`LIDEC_OFS_FW_LO, 32'h0);
    rd("fw_lo", `LIDEC_OFS_FW_LO, 32'h0246_8ace);
    rd("fw_hi", `LIDEC_OFS_FW_HI, {10'h15a, 6'h24, 16'h5678});
    rd("status", `LIDEC_OFS_STATUS, 32'h3);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rd("status_clr", `LIDEC_OFS_STATUS, 32'h0);
    i_far.uid_load(32'h5555_aaaa);
    @(posedge sys_clk);
    chk("uid_undetected", 32'h0, unique_id_lower_part);
    eeprom_detected <= 1'b1;
    @(posedge sys_clk);
    i_far.uid_load(32'hcafe_0123);
    @(posedge sys_clk);
    chk("uid_part", 32'hcafe_0123, unique_id_lower_part);
    i_far.uid_load(32'h1111_2222);
    rd("uid_lock", `LIDEC_OFS_UID_LO, 32'hcafe_0123);
    rd("status_uid", `LIDEC_OFS_STATUS, 32'h4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
